/* srw_cfg.svh */
// timing constants for the reset supervisor and watchdog
`ifndef SRW_CFG_SVH
`define SRW_CFG_SVH

`define SRW_CLK_HZ          125_000_000
// time base tick period in ns, one tick per microsecond
`define SRW_TICK_NS         1000
`define SRW_TICK_CYC        ((`SRW_TICK_NS * 125) / 1000)
// reset timeout in microseconds
`define SRW_RESET_US        1120000
// watchdog startup period in microseconds, at least 35 s
`define SRW_WD_START_US     35000000
// watchdog normal period in microseconds, at least 1.12 s
`define SRW_WD_NORM_US      1120000
`define SRW_CNT_W           32
`define SRW_TB_W            8

`endif

/* srw_pkg.sv */
// types for the reset supervisor and watchdog
`include "srw_cfg.svh"
package srw_pkg;

    // synchronised input levels
    typedef struct packed {
        logic primary_supply;
        logic secondary_supply;
        logic aux_undervoltage_sense;
        logic manual_reset_request_n;
        logic kick;
        logic kick_float;
    } srw_in_t;

    // reset output group
    typedef struct packed {
        logic primary_reset_n;
        logic secondary_reset_n;
        logic primary_reset;
    } srw_out_t;

    // watchdog phase
    typedef enum logic [2:0] {
        SRW_WD_OFF   = 3'b001,
        SRW_WD_START = 3'b010,
        SRW_WD_NORM  = 3'b100
    } srw_wd_st_t;

endpackage : srw_pkg

/* srw_hold_timer.sv */
// reset stretcher: holds a reset low for a timeout after its cause clears
`timescale 1ns/1ps
module srw_hold_timer
    import srw_pkg::*;
#(
    parameter logic [`SRW_CNT_W-1:0] TIMEOUT = `SRW_RESET_US
) (
    input  wire logic CLK_SYS,
    input  wire logic RST,
    input  wire logic tick,
    input  wire logic cause,
    output logic      reset_n
);

    typedef struct packed {
        logic [`SRW_CNT_W-1:0] cnt;
        logic                  rst_n;
    } srw_hold_st_t;

    srw_hold_st_t st;
    srw_hold_st_t next_st;

    ////////////////////////////////////////////////////////////////////////
    // count ticks with the cause clear; any cause restarts from zero
    always_comb begin
        next_st = st;
        if (cause) begin
            next_st.cnt   = '0;
            next_st.rst_n = 1'b0;
        end else if (!st.rst_n && tick) begin
            if (st.cnt >= TIMEOUT - 1) begin
                next_st.rst_n = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 1'b1;
            end
        end
    end

    // reset holds outputs asserted from power-on
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign reset_n = st.rst_n;

endmodule : srw_hold_timer

/* srw_supervisor.sv */
// reset supervisor with manual reset, aux sense and watchdog
`timescale 1ns/1ps
// What this block does
// - secondary reset from supplies and manual only
// - secondary reset held timeout after clear
// - manual reset low asserts reset outputs
// - reset held while manual low plus timeout
// - stuck kick input raises watchdog fault
// - watchdog cleared on reset or edge
// - long startup timeout until first edge
// - normal timeout after first edge
// - floating kick input disables watchdog
// - aux undervoltage asserts primary reset
// - primary reset from all causes, held
// - relapse restarts the reset timeout
// - active-high output is primary complement
module srw_supervisor
    import srw_pkg::*;
#(
    parameter logic [`SRW_CNT_W-1:0] RESET_TICKS    = `SRW_RESET_US,
    parameter logic [`SRW_CNT_W-1:0] WD_START_TICKS = `SRW_WD_START_US,
    parameter logic [`SRW_CNT_W-1:0] WD_NORM_TICKS  = `SRW_WD_NORM_US
) (
    input  wire logic CLK_SYS,
    input  wire logic RST,
    input  wire logic PRIMARY_SUPPLY,
    input  wire logic SECONDARY_SUPPLY,
    input  wire logic AUX_UNDERVOLTAGE_SENSE,
    input  wire logic MANUAL_RESET_REQUEST_N,
    input  wire logic WATCHDOG_KICK_INPUT,
    input  wire logic WATCHDOG_KICK_FLOAT,
    output logic      PRIMARY_RESET_N,
    output logic      SECONDARY_RESET_N,
    output logic      PRIMARY_RESET,
    output logic      WATCHDOG_FAULT
);

    // cut on purpose: one tick spans fewer cycles than the counter can hold
    localparam logic [`SRW_TB_W-1:0] TICK_LAST = `SRW_TB_W'((`SRW_TICK_CYC) - 1);

    typedef struct packed {
        srw_in_t               s1;
        srw_in_t               s2;
        logic                  kick_prev;
        logic [`SRW_TB_W-1:0]  tb;
        logic                  tick;
        srw_wd_st_t            wd;
        logic [`SRW_CNT_W-1:0] wd_cnt;
        logic                  fault;
    } srw_st_t;

    srw_st_t  st;
    srw_st_t  next_st;
    srw_in_t  pins;
    srw_out_t outs;
    logic     pri_cause;
    logic     sec_cause;
    logic     kick_edge;

    // gather the raw pins
    assign pins = '{primary_supply:         PRIMARY_SUPPLY,
                    secondary_supply:       SECONDARY_SUPPLY,
                    aux_undervoltage_sense: AUX_UNDERVOLTAGE_SENSE,
                    manual_reset_request_n: MANUAL_RESET_REQUEST_N,
                    kick:                   WATCHDOG_KICK_INPUT,
                    kick_float:             WATCHDOG_KICK_FLOAT};

    ////////////////////////////////////////////////////////////////////////
    // returns the watchdog limit for the current phase
    function automatic logic [`SRW_CNT_W-1:0] wd_limit(input srw_wd_st_t ph);
        wd_limit = (ph == SRW_WD_NORM) ? WD_NORM_TICKS : WD_START_TICKS;
    endfunction : wd_limit

    // edge seen on the second synchroniser stage only
    assign kick_edge = st.s2.kick ^ st.kick_prev;

    assign sec_cause = !st.s2.primary_supply | !st.s2.secondary_supply
                     | !st.s2.manual_reset_request_n;
    // primary causes with aux and fault
    assign pri_cause = sec_cause | !st.s2.aux_undervoltage_sense | st.fault;

    ////////////////////////////////////////////////////////////////////////
    // next state: synchronisers, time base, watchdog
    always_comb begin
        next_st = st;
        next_st.s1        = pins;
        next_st.s2        = st.s1;
        next_st.kick_prev = st.s2.kick;
        if (st.tb == TICK_LAST) begin
            next_st.tb   = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.tb   = st.tb + 1'b1;
            next_st.tick = 1'b0;
        end
        next_st.fault = 1'b0;
        unique case (st.wd)
            SRW_WD_OFF: begin
                next_st.wd_cnt = '0;
                if (outs.primary_reset_n && !st.s2.kick_float) begin
                    next_st.wd = SRW_WD_START;
                end
            end
            SRW_WD_START, SRW_WD_NORM: begin
                if (!outs.primary_reset_n || st.s2.kick_float) begin
                    next_st.wd     = SRW_WD_OFF;
                    next_st.wd_cnt = '0;
                end else if (kick_edge) begin
                    next_st.wd     = SRW_WD_NORM;
                    next_st.wd_cnt = '0;
                end else if (st.tick) begin
                    if (st.wd_cnt >= wd_limit(st.wd) - 1) begin
                        next_st.fault  = 1'b1;
                        next_st.wd     = SRW_WD_OFF;
                        next_st.wd_cnt = '0;
                    end else begin
                        // count against startup or normal limit
                        next_st.wd_cnt = st.wd_cnt + 1'b1;
                    end
                end
            end
            default: begin
                next_st.wd     = SRW_WD_OFF;
                next_st.wd_cnt = '0;
            end
        endcase
    end

    // register all state
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            st    <= '0;
            st.wd <= SRW_WD_OFF;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // primary stretcher
    srw_hold_timer #(
        .TIMEOUT (RESET_TICKS)
    ) u_pri_hold (
        .CLK_SYS (CLK_SYS),
        .RST     (RST),
        .tick    (st.tick),
        .cause   (pri_cause),
        .reset_n (outs.primary_reset_n)
    );

    srw_hold_timer #(
        .TIMEOUT (RESET_TICKS)
    ) u_sec_hold (
        .CLK_SYS (CLK_SYS),
        .RST     (RST),
        .tick    (st.tick),
        .cause   (sec_cause),
        .reset_n (outs.secondary_reset_n)
    );

    assign outs.primary_reset = !outs.primary_reset_n;

    assign PRIMARY_RESET_N   = outs.primary_reset_n;
    assign SECONDARY_RESET_N = outs.secondary_reset_n;
    assign PRIMARY_RESET     = outs.primary_reset;
    assign WATCHDOG_FAULT    = st.fault;

endmodule : srw_supervisor

/* srw_host_model.sv */
// host processor model that toggles the watchdog kick line
`timescale 1ns/1ps
module srw_host_model
    import srw_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        run,
    input  wire logic [15:0] period,
    output logic             kick
);
    logic [15:0] cnt;
    initial kick = 1'b0;
    // toggle kick well inside the timeout
    always @(posedge clk) begin
        if (!run || cnt >= period) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 16'h0001;
        end
        if (run && cnt >= period) begin
            kick <= !kick;
        end
    end
endmodule : srw_host_model

/* srw_supervisor_monitor.sv */
// port assertions for the reset supervisor
`timescale 1ns/1ps
module srw_supervisor_monitor
    import srw_pkg::*;
#(
    parameter logic [31:0] RESET_TICKS = 4
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic PRIMARY_SUPPLY,
    input wire logic SECONDARY_SUPPLY,
    input wire logic AUX_UNDERVOLTAGE_SENSE,
    input wire logic MANUAL_RESET_REQUEST_N,
    input wire logic WATCHDOG_KICK_FLOAT,
    input wire logic PRIMARY_RESET_N,
    input wire logic SECONDARY_RESET_N,
    input wire logic PRIMARY_RESET,
    input wire logic WATCHDOG_FAULT
);
    logic [31:0] calm;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // cycles since the secondary causes cleared
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            calm <= '0;
        end else if (!(PRIMARY_SUPPLY && SECONDARY_SUPPLY && MANUAL_RESET_REQUEST_N)) begin
            calm <= '0;
        end else begin
            calm <= calm + 32'h0000_0001;
        end
    end
    sequence s_fault; WATCHDOG_FAULT; endsequence
    sequence s_low; ##[0:3] !PRIMARY_RESET_N; endsequence
    AST_COMPL: assert property (PRIMARY_RESET == !PRIMARY_RESET_N)
        else $error("active-high output not complement");
    AST_MAN: assert property ($fell(MANUAL_RESET_REQUEST_N) |-> ##[1:5] !SECONDARY_RESET_N)
        else $error("manual reset not seen");
    AST_SUP: assert property (!PRIMARY_SUPPLY |-> ##[1:5] !PRIMARY_RESET_N)
        else $error("supply fault not seen");
    AST_AUX: assert property (!AUX_UNDERVOLTAGE_SENSE |-> ##[1:5] !PRIMARY_RESET_N)
        else $error("aux undervoltage not seen");
    AST_FLT: assert property (s_fault |-> s_low)
        else $error("fault without reset");
    AST_FLOAT: assert property (WATCHDOG_KICK_FLOAT[*5] |-> !WATCHDOG_FAULT)
        else $error("fault while kick floats");
    AST_HOLD: assert property ($rose(SECONDARY_RESET_N) |-> calm >= (RESET_TICKS - 1) * 125
        && calm <= (RESET_TICKS + 1) * 125 + 8)
        else $error("secondary hold length wrong");
    AST_SEC: assert property ($fell(SECONDARY_RESET_N) |-> calm < 8)
        else $error("secondary reset without its cause");
endmodule : srw_supervisor_monitor
bind srw_supervisor srw_supervisor_monitor #(.RESET_TICKS(RESET_TICKS)) u_mon (
    .CLK_SYS(CLK_SYS), .RST(RST), .PRIMARY_SUPPLY(PRIMARY_SUPPLY),
    .SECONDARY_SUPPLY(SECONDARY_SUPPLY), .AUX_UNDERVOLTAGE_SENSE(AUX_UNDERVOLTAGE_SENSE),
    .MANUAL_RESET_REQUEST_N(MANUAL_RESET_REQUEST_N), .WATCHDOG_KICK_FLOAT(WATCHDOG_KICK_FLOAT),
    .PRIMARY_RESET_N(PRIMARY_RESET_N), .SECONDARY_RESET_N(SECONDARY_RESET_N),
    .PRIMARY_RESET(PRIMARY_RESET), .WATCHDOG_FAULT(WATCHDOG_FAULT));

/* tb_supervisor_reset_watchdog.sv */
// self-checking bench for the reset supervisor
`timescale 1ns/1ps
module tb_supervisor_reset_watchdog;
    import srw_pkg::*;
    localparam int RT = 4;
    localparam int WS = 40;
    localparam int WN = 10;
    logic        clk_sys, rst, ps, ss, aux, mr_n, flt, run, kick, prst_n, srst_n, prst, wfault;
    logic [15:0] per;
    logic [31:0] seed;
    int          n_mismatch, cmp_count, cyc, nf, n, k, i;
    srw_supervisor #(.RESET_TICKS(RT), .WD_START_TICKS(WS), .WD_NORM_TICKS(WN)) dut (
        .CLK_SYS(clk_sys), .RST(rst), .PRIMARY_SUPPLY(ps), .SECONDARY_SUPPLY(ss),
        .AUX_UNDERVOLTAGE_SENSE(aux), .MANUAL_RESET_REQUEST_N(mr_n),
        .WATCHDOG_KICK_INPUT(kick), .WATCHDOG_KICK_FLOAT(flt), .PRIMARY_RESET_N(prst_n),
        .SECONDARY_RESET_N(srst_n), .PRIMARY_RESET(prst), .WATCHDOG_FAULT(wfault));
    srw_host_model host (.clk(clk_sys), .run(run), .period(per), .kick(kick));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // cycles of a tick count
    function automatic int hc(input int ticks);
        return ticks * 125;
    endfunction : hc
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic chk(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc_wait(input int c);
        repeat (c) @(posedge clk_sys);
    endtask : cyc_wait
    task automatic wait_fault(input int lim);
        n = 0;
        while (wfault !== 1'b1 && n < lim) begin
            @(posedge clk_sys);
            n++;
        end
    endtask : wait_fault
    task automatic set_cause(input int c, input logic v);
        case (c)
            0: ps <= v;
            1: ss <= v;
            2: aux <= v;
            default: mr_n <= v;
        endcase
    endtask : set_cause
    task automatic stop_test;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    // cycle ceiling and fault tally
    always @(posedge clk_sys) begin
        cyc++;
        if (wfault === 1'b1) nf++;
        if (cyc == 40000) begin
            n_mismatch++;
            stop_test();
        end
    end
    initial begin
        {rst, ps, ss, aux, mr_n, flt, run} = 7'b1111100;
        per = 16'h0100;
        seed = 32'h0cc7_19d3;
        cyc_wait(5);
        chk(srst_n, 1'b0);
        rst <= 1'b0;
        run <= 1'b1;
        cyc_wait(hc(RT) - 130);
        chk(prst_n, 1'b0);
        cyc_wait(400);
        chk(prst_n & srst_n, 1'b1);
        // every cause, random length, relapse in the hold
        for (k = 0; k < 8; k++) begin
            i = k % 4;
            seed = xs(seed);
            // random kick spacing, always well inside the normal timeout
            per <= {8'h00, seed[15:8]} + 16'h0040;
            set_cause(i, 1'b0);
            cyc_wait(6 + seed[7:0]);
            chk(prst_n, 1'b0);
            chk(srst_n, i == 2);
            set_cause(i, 1'b1);
            cyc_wait(250);
            set_cause(i, 1'b0);
            cyc_wait(2);
            set_cause(i, 1'b1);
            cyc_wait(hc(RT) - 130);
            chk(prst_n, 1'b0);
            cyc_wait(400);
            chk(prst_n & srst_n, 1'b1);
        end
        chk(nf == 0, 1'b1);
        // stop the host just after a kick edge so the fault time is known
        @(kick);
        @(posedge clk_sys);
        run <= 1'b0;
        wait_fault(hc(WN) + 300);
        chk(n >= hc(WN - 3) && n < hc(WN) + 300, 1'b1);
        cyc_wait(6);
        chk(prst_n | !srst_n, 1'b0);
        wait_fault(hc(RT + WS) + 400);
        chk(n >= hc(RT + WS - 2) && n < hc(RT + WS) + 400, 1'b1);
        flt <= 1'b1;
        cyc_wait(2);
        nf = 0;
        cyc_wait(hc(RT + WS) + 900);
        chk(nf == 0, 1'b1);
        rst <= 1'b1;
        cyc_wait(3);
        chk(prst, 1'b1);
        stop_test();
    end
endmodule : tb_supervisor_reset_watchdog
